// >>> include/nvm_pkg.sv
// Shared constants, types and state codes for the serial byte-memory slave.
// Assumes a two-wire link driven by one master and a 20 MHz system clock.
package nvm_pkg;

   // Memory geometry
   localparam int ADDR_W = 13;
   localparam int MEM_DEPTH = 8192;
   localparam int BYTE_W = 8;
   localparam int HI_ADDR_W = ADDR_W - BYTE_W;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;

   // Bit counter: eight data bits, then the acknowledge clock
   localparam logic [3:0] LAST_DATA_CNT = 4'h7;
   localparam logic [3:0] ACK_CNT = 4'h8;
   localparam logic [3:0] FIRST_BIT_CNT = 4'h1;

   // Fields of the device address word
   localparam int TYPE_MSB = 7;
   localparam int TYPE_LSB = 4;
   localparam int SEL_MSB = 3;
   localparam int SEL_LSB = 1;
   localparam int RW_POS = 0;

   // Reset values
   localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
   localparam logic [HI_ADDR_W-1:0] HI_RESET = 5'h00;
   localparam logic [1:0] SYNC_RESET = 2'h0;

   // Transfer phases
   typedef enum logic [2:0] {
      NVM_IDLE,
      NVM_DEV,
      NVM_ADDR_HI,
      NVM_ADDR_LO,
      NVM_WDATA,
      NVM_RDATA
   } nvm_state_t;

   // Bus condition toggles from the start/stop detector
   typedef struct packed {
      logic start_tog;
      logic stop_tog;
   } nvm_cond_t;

   // Link events carried to the system clock as toggles
   typedef struct packed {
      logic written;
      logic blocked;
   } nvm_event_t;

endpackage

// >>> design/nvm_cond_det.sv
// Start and stop condition detector for the two-wire link.
// Assumes the data line is only allowed to move while the clock is high
// at a start or stop; those edges are used here as the capture clock.
`timescale 1ns/1ps

module nvm_cond_det
(
   // Link pins
   input wire logic scl_i,
   input wire logic sda_i,
   // Condition toggles
   output nvm_pkg::nvm_cond_t cond_o
);

   // Power-up value so the toggles never start unknown
   logic start_tog = 1'b0;
   logic stop_tog = 1'b0;

   // Data falling with clock high marks a start
   always_ff @(negedge sda_i)
   begin
      if (scl_i)
      begin
         start_tog <= ~start_tog; // [RULE2]
      end
   end

   // Data rising with clock high marks a stop
   always_ff @(posedge sda_i)
   begin
      if (scl_i)
      begin
         stop_tog <= ~stop_tog; // [RULE4]
      end
   end

   // Toggles rather than levels: no reset path is needed on the data clock
   assign cond_o.start_tog = start_tog;
   assign cond_o.stop_tog = stop_tog;

endmodule

// >>> design/nvm_i2c_slave.sv
// Two-wire slave front end of an 8192 x 8 byte memory, array included.
// Assumes the master owns the serial clock; the link logic runs on it.
// Write events for the system side are carried to the 20 MHz clock by toggles, busy as a level.
`timescale 1ns/1ps

// Notes on behaviour
// RULE1 - Sample on clock rise, drive after fall
// RULE2 - Start: data falls while clock high
// RULE3 - Data moves only while clock low
// RULE4 - Stop: data rises while clock high, standby
// RULE5 - Ninth clock: transmitter releases, receiver pulls low
// RULE6 - Stop before acknowledge abandons the operation
// RULE7 - After not-acknowledge the bus is released
// RULE8 - First byte: type, select, direction, MSB first
// RULE9 - Acknowledge only when select matches pins
// RULE10 - Eighth bit picks write or read
// RULE11 - Mismatch: no acknowledge, standby until start
// RULE12 - Open select pins read low
// RULE13 - Two address bytes, high first, acknowledged
// RULE14 - Write: take byte, then acknowledge low
// RULE15 - Read: eight bits out, then release
// RULE16 - Address is low thirteen bits
// RULE17 - Successive bytes stored at successive addresses
// RULE18 - Write address wraps to zero
// RULE19 - Byte committed when its acknowledge completes
// RULE20 - Protect pin high blocks all writes
// RULE21 - Open protect pin reads low
// RULE22 - Current read returns last address plus one
// RULE23 - Random read: address, repeated start, read
// RULE24 - Sequential read continues and wraps
// RULE25 - Master ends reads with not-acknowledge
// RULE26 - Protected writes still acknowledge and advance
// RULE27 - Address counter starts at zero
module nvm_i2c_slave
#(
   parameter logic [3:0] TYPE_CODE = 4'hb // Arbitrary device type code
)
(
   // System clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   // Link clock from the master
   input wire logic SCL_I,
   // Serial data pin, open drain
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_O,
   // Straps
   input wire logic [2:0] DEVICE_SELECT_PINS_I,
   input wire logic WP_I,
   // Status on the system clock
   output logic BUSY_O,
   output logic BYTE_WRITTEN_O,
   output logic WRITE_BLOCKED_O
);

   // ---------------- Link clock domain ----------------

   nvm_pkg::nvm_cond_t cond;
   nvm_pkg::nvm_state_t state;
   nvm_pkg::nvm_state_t next_state;
   logic [1:0] rst_sync;
   logic rst_lnk;
   logic [2:0] sel_meta;
   logic [2:0] sel_s;
   logic wp_meta;
   logic wp_s;
   logic start_seen;
   logic stop_seen;
   logic start_ev;
   logic stop_ev;
   logic [3:0] bit_cnt;
   logic [nvm_pkg::BYTE_W-1:0] shreg;
   logic [nvm_pkg::BYTE_W-1:0] full_byte;
   logic ack_en;
   logic next_ack;
   logic dev_match;
   logic ack_clk;
   logic [nvm_pkg::ADDR_W-1:0] cur_addr;
   logic [nvm_pkg::HI_ADDR_W-1:0] addr_hi;
   logic [nvm_pkg::BYTE_W-1:0] rd_byte;
   logic [nvm_pkg::BYTE_W-1:0] mem [nvm_pkg::MEM_DEPTH];
   logic next_oe;
   logic sda_oe;
   logic sda_out;
   logic busy_lnk;
   nvm_pkg::nvm_event_t ev_tog;

   // Start and stop arrive on data edges, outside any clock
   nvm_cond_det u_cond
   (
      .scl_i (SCL_I),
      .sda_i (SDA_I),
      .cond_o (cond)
   );

   // System reset brought onto the link clock
   always_ff @(posedge SCL_I)
   begin
      rst_sync <= {rst_sync[0], RST_I};
   end

   assign rst_lnk = rst_sync[1];

   // Straps pass two flops before use; pads pull them low when open
   always_ff @(posedge SCL_I)
   begin
      sel_meta <= DEVICE_SELECT_PINS_I; // [RULE12]
      sel_s <= sel_meta;
      wp_meta <= WP_I; // [RULE21]
      wp_s <= wp_meta;
   end

   // A condition toggle settles a full clock-low phase before the next rise
   assign start_ev = cond.start_tog != start_seen;
   assign stop_ev = cond.stop_tog != stop_seen;

   // Incoming bit joins the byte on the rising edge
   assign full_byte = {shreg[6:0], SDA_I}; // [RULE1]

   // Type and select fields checked MSB first, select in pin order 2..0
   assign dev_match = (full_byte[nvm_pkg::TYPE_MSB:nvm_pkg::TYPE_LSB] == TYPE_CODE)
      && (full_byte[nvm_pkg::SEL_MSB:nvm_pkg::SEL_LSB] == sel_s); // [RULE8] [RULE9]

   // Ninth rising edge of a byte, not pre-empted by a condition
   assign ack_clk = (state != nvm_pkg::NVM_IDLE) && (bit_cnt == nvm_pkg::ACK_CNT)
      && !start_ev && !stop_ev;

   // Whether to acknowledge the byte that completes on this rise
   always_comb
   begin
      next_ack = 1'b0;
      unique case (state)
         nvm_pkg::NVM_IDLE: next_ack = 1'b0;
         nvm_pkg::NVM_DEV: next_ack = dev_match; // [RULE11]
         nvm_pkg::NVM_ADDR_HI: next_ack = 1'b1; // [RULE13]
         nvm_pkg::NVM_ADDR_LO: next_ack = 1'b1; // [RULE13]
         nvm_pkg::NVM_WDATA: next_ack = 1'b1; // [RULE14] [RULE26]
         nvm_pkg::NVM_RDATA: next_ack = 1'b0; // [RULE15]
      endcase
   end

   // Phase that follows the acknowledge clock
   always_comb
   begin
      next_state = nvm_pkg::NVM_IDLE;
      unique case (state)
         nvm_pkg::NVM_IDLE: next_state = nvm_pkg::NVM_IDLE;
         nvm_pkg::NVM_DEV:
         begin
            if (!ack_en)
            begin
               next_state = nvm_pkg::NVM_IDLE; // [RULE11]
            end
            else if (shreg[nvm_pkg::RW_POS])
            begin
               next_state = nvm_pkg::NVM_RDATA; // [RULE10] [RULE22] [RULE23]
            end
            else
            begin
               next_state = nvm_pkg::NVM_ADDR_HI; // [RULE10]
            end
         end
         nvm_pkg::NVM_ADDR_HI: next_state = nvm_pkg::NVM_ADDR_LO; // [RULE13]
         nvm_pkg::NVM_ADDR_LO: next_state = nvm_pkg::NVM_WDATA;
         nvm_pkg::NVM_WDATA: next_state = nvm_pkg::NVM_WDATA; // [RULE17]
         nvm_pkg::NVM_RDATA:
         begin
            // Master acknowledge keeps the read going; a high level ends it
            if (SDA_I)
            begin
               next_state = nvm_pkg::NVM_IDLE; // [RULE7] [RULE25]
            end
            else
            begin
               next_state = nvm_pkg::NVM_RDATA; // [RULE24]
            end
         end
      endcase
   end

   // Transfer sequencing on the rising edge; start outranks stop
   always_ff @(posedge SCL_I)
   begin
      if (rst_lnk)
      begin
         state <= nvm_pkg::NVM_IDLE;
         bit_cnt <= 4'h0;
         shreg <= nvm_pkg::BYTE_RESET;
         ack_en <= 1'b0;
         // Track the live toggles so no stale condition follows reset
         start_seen <= cond.start_tog;
         stop_seen <= cond.stop_tog;
      end
      else
      begin
         start_seen <= cond.start_tog;
         stop_seen <= cond.stop_tog;
         if (start_ev)
         begin
            // First address bit is already on the line at this rise
            state <= nvm_pkg::NVM_DEV; // [RULE2]
            bit_cnt <= nvm_pkg::FIRST_BIT_CNT;
            shreg <= {7'h00, SDA_I};
            ack_en <= 1'b0;
         end
         else if (stop_ev)
         begin
            // Anything not yet acknowledged is simply dropped
            state <= nvm_pkg::NVM_IDLE; // [RULE4] [RULE6]
            bit_cnt <= 4'h0;
            ack_en <= 1'b0;
         end
         else if (state != nvm_pkg::NVM_IDLE)
         begin
            if (bit_cnt != nvm_pkg::ACK_CNT)
            begin
               shreg <= full_byte;
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == nvm_pkg::LAST_DATA_CNT)
               begin
                  ack_en <= next_ack; // [RULE5]
               end
            end
            else
            begin
               bit_cnt <= 4'h0;
               ack_en <= 1'b0;
               state <= next_state;
            end
         end
      end
   end

   // Address counter and read data; counter starts at zero for repeatability
   always_ff @(posedge SCL_I)
   begin
      if (rst_lnk)
      begin
         cur_addr <= nvm_pkg::ADDR_RESET; // [RULE27]
         addr_hi <= nvm_pkg::HI_RESET;
         rd_byte <= nvm_pkg::BYTE_RESET;
      end
      else if (ack_clk)
      begin
         unique case (state)
            nvm_pkg::NVM_ADDR_HI:
            begin
               // Upper three bits of the high byte are discarded
               addr_hi <= shreg[nvm_pkg::HI_ADDR_W-1:0]; // [RULE16]
            end
            nvm_pkg::NVM_ADDR_LO:
            begin
               cur_addr <= {addr_hi, shreg}; // [RULE13]
            end
            nvm_pkg::NVM_WDATA:
            begin
               // Thirteen-bit counter wraps to zero by itself
               cur_addr <= cur_addr + 13'h0001; // [RULE17] [RULE18] [RULE26]
            end
            nvm_pkg::NVM_DEV:
            begin
               if (ack_en && shreg[nvm_pkg::RW_POS])
               begin
                  rd_byte <= mem[cur_addr]; // [RULE22]
                  cur_addr <= cur_addr + 13'h0001;
               end
            end
            nvm_pkg::NVM_RDATA:
            begin
               if (!SDA_I)
               begin
                  rd_byte <= mem[cur_addr]; // [RULE24]
                  cur_addr <= cur_addr + 13'h0001;
               end
            end
            default:
            begin
               cur_addr <= cur_addr;
            end
         endcase
      end
   end

   // Commit on the acknowledge clock, so no write cycle follows the stop
   always_ff @(posedge SCL_I)
   begin
      if (ack_clk && (state == nvm_pkg::NVM_WDATA) && !wp_s)
      begin
         mem[cur_addr] <= shreg; // [RULE19] [RULE20]
      end
   end

   // Event toggles for the system side
   always_ff @(posedge SCL_I)
   begin
      if (rst_lnk)
      begin
         ev_tog <= '0;
         busy_lnk <= 1'b0;
      end
      else
      begin
         busy_lnk <= (state != nvm_pkg::NVM_IDLE);
         if (ack_clk && (state == nvm_pkg::NVM_WDATA))
         begin
            if (wp_s)
            begin
               ev_tog.blocked <= ~ev_tog.blocked; // [RULE26]
            end
            else
            begin
               ev_tog.written <= ~ev_tog.written;
            end
         end
      end
   end

   // Pull low for our acknowledge or a zero read bit, else release
   always_comb
   begin
      next_oe = 1'b0;
      if (bit_cnt == nvm_pkg::ACK_CNT)
      begin
         next_oe = ack_en && !start_ev && !stop_ev; // [RULE5] [RULE15]
      end
      else if (state == nvm_pkg::NVM_RDATA)
      begin
         next_oe = !rd_byte[3'h7 - bit_cnt[2:0]]; // [RULE15]
      end
   end

   // Drive changes only on the falling edge, clear of clock-high periods
   always_ff @(negedge SCL_I)
   begin
      if (rst_lnk)
      begin
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
      end
      else
      begin
         sda_oe <= next_oe; // [RULE1] [RULE3] [RULE7]
         sda_out <= 1'b0;
      end
   end

   assign SDA_OE_O = sda_oe;
   assign SDA_O = sda_out;

   // ---------------- System clock domain ----------------

   logic [1:0] busy_sync;
   logic busy_r;
   nvm_pkg::nvm_event_t ev_meta;
   nvm_pkg::nvm_event_t ev_s;
   nvm_pkg::nvm_event_t ev_d;
   logic [1:0] pulse;

   // Busy level and event toggles cross through two flops each
   always_ff @(posedge REF_CLK_I)
   begin
      if (RST_I)
      begin
         busy_sync <= nvm_pkg::SYNC_RESET;
         busy_r <= 1'b0;
         ev_meta <= '0;
         ev_s <= '0;
         ev_d <= '0;
      end
      else
      begin
         busy_sync <= {busy_sync[0], busy_lnk};
         busy_r <= busy_sync[1];
         ev_meta <= ev_tog;
         ev_s <= ev_meta;
         ev_d <= ev_s;
      end
   end

   // One pulse per toggle; a stopped link clock simply freezes the toggles
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_pulse
         always_ff @(posedge REF_CLK_I)
         begin
            if (RST_I)
            begin
               pulse[gi] <= 1'b0;
            end
            else
            begin
               pulse[gi] <= ev_s[gi] ^ ev_d[gi];
            end
         end
      end
   endgenerate

   assign BUSY_O = busy_r;
   assign BYTE_WRITTEN_O = pulse[1];
   assign WRITE_BLOCKED_O = pulse[0];

endmodule

// >>> testbench/nvm_i2c_monitor.sv
// Checker for the byte-memory slave, bound to its top-level ports.
// Assumes one master on the link and straps held steady within a frame.
`timescale 1ns/1ps
module nvm_i2c_monitor
#(
   parameter logic [3:0] TYPE_CODE = 4'hb
)
(
   // Clocks and reset
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic SCL_I,
   // Link and straps
   input wire logic SDA_I,
   input wire logic SDA_OE_O,
   input wire logic [2:0] DEVICE_SELECT_PINS_I,
   input wire logic WP_I,
   // Status
   input wire logic BUSY_O,
   input wire logic BYTE_WRITTEN_O,
   input wire logic WRITE_BLOCKED_O
);
   logic st_tog = 1'b0;
   logic sp_tog = 1'b0;
   logic st_seen = 1'b0;
   logic sp_seen = 1'b0;
   logic hit = 1'b0;
   logic rd = 1'b0;
   logic oe_rise = 1'b0;
   logic [3:0] nbit = 4'h0;
   logic [1:0] nbyte = 2'h3;
   logic [7:0] sh = 8'h00;

   // Own start and stop view, data edges used as clock
   always_ff @(negedge SDA_I)
      if (SCL_I)
         st_tog <= ~st_tog;
   always_ff @(posedge SDA_I)
      if (SCL_I)
         sp_tog <= ~sp_tog;

   // Bit and byte position; hit marks an acknowledged device word
   always_ff @(posedge SCL_I)
   begin
      st_seen <= st_tog;
      sp_seen <= sp_tog;
      oe_rise <= SDA_OE_O;
      sh <= {sh[6:0], SDA_I};
      if (st_tog != st_seen)
      begin
         nbit <= 4'h1;
         nbyte <= 2'h0;
      end
      else
      begin
         nbit <= (nbit == 4'h9) ? 4'h1 : nbit + 4'h1;
         if (sp_tog != sp_seen)
            nbyte <= 2'h3;
         else if (nbit == 4'h9 && nbyte != 2'h3)
            nbyte <= nbyte + 2'h1;
      end
      if (st_tog != st_seen || sp_tog != sp_seen)
         hit <= 1'b0;
      else if (nbyte == 2'h0 && nbit == 4'h8)
      begin
         hit <= sh[7:4] == TYPE_CODE && sh[3:1] == DEVICE_SELECT_PINS_I;
         rd <= sh[0];
      end
   end

   // Value seen at the fall is the one held through the high phase
   chk_stable_high: assert property (@(negedge SCL_I) disable iff (RST_I)
      SDA_OE_O == oe_rise) else $error("data drive moved while clock high");
   chk_dev_ack: assert property (@(negedge SCL_I) disable iff (RST_I)
      nbyte == 2'h0 && nbit == 4'h9 |-> SDA_OE_O == hit) else $error("device word ack wrong");
   chk_write_ack: assert property (@(negedge SCL_I) disable iff (RST_I)
      hit && !rd && nbyte != 2'h0 && nbit == 4'h9 |-> SDA_OE_O) else $error("write byte not acked");
   chk_read_release: assert property (@(negedge SCL_I) disable iff (RST_I)
      hit && rd && nbyte != 2'h0 && nbit == 4'h9 |-> !SDA_OE_O) else $error("read ack not released");
   chk_idle_quiet: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      !BUSY_O |-> !SDA_OE_O) else $error("drive while idle");
   chk_block_wp: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      WRITE_BLOCKED_O |-> WP_I && !BYTE_WRITTEN_O) else $error("block without protect");
   chk_write_open: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      BYTE_WRITTEN_O |-> !WP_I) else $error("write while protected");
   chk_pulse_once: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      $rose(BYTE_WRITTEN_O) |=> !BYTE_WRITTEN_O [*8]) else $error("write pulse too long");

   // Main scenarios reached
   cov_write: cover property (@(negedge SCL_I) hit && !rd && nbyte != 2'h0 && nbit == 4'h9);
   cov_read: cover property (@(negedge SCL_I) hit && rd && nbyte != 2'h0 && nbit == 4'h9);
   cov_block: cover property (@(posedge REF_CLK_I) WRITE_BLOCKED_O);
endmodule

bind nvm_i2c_slave nvm_i2c_monitor #(.TYPE_CODE(TYPE_CODE)) i_mon (.REF_CLK_I(REF_CLK_I),
   .RST_I(RST_I), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_OE_O(SDA_OE_O),
   .DEVICE_SELECT_PINS_I(DEVICE_SELECT_PINS_I), .WP_I(WP_I), .BUSY_O(BUSY_O),
   .BYTE_WRITTEN_O(BYTE_WRITTEN_O), .WRITE_BLOCKED_O(WRITE_BLOCKED_O));

// >>> testbench/nvm_bus_master.sv
// Behavioural two-wire master, 64 ns bit period, open-drain data.
// Assumes the bench resolves the wire with a pull-up; clock idles high.
`timescale 1ns/1ps
module nvm_bus_master
(
   // Link pins
   output logic scl_o,
   output logic sda_low_o,
   input wire logic sda_i
);
   localparam time Q = 16;

   // Bus idle: clock high, data released
   initial
   begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   // Free clocks for reset, data left released
   task automatic pulses(input int n);
      sda_low_o = 1'b0;
      repeat (n)
      begin
         #(2*Q) scl_o = 1'b0;
         #(2*Q) scl_o = 1'b1;
      end
   endtask

   // Data set up only while clock low
   task automatic bit_out(input logic b);
      sda_low_o = ~b;
      #Q scl_o = 1'b1;
      #(2*Q) scl_o = 1'b0;
      #Q;
   endtask

   task automatic bit_in(output logic b);
      sda_low_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q b = sda_i;
      #Q scl_o = 1'b0;
      #Q;
   endtask

   task automatic start();
      sda_low_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q sda_low_o = 1'b1;
      #Q scl_o = 1'b0;
      #Q;
   endtask

   // Clock then stays high, bus released
   task automatic stop();
      sda_low_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q sda_low_o = 1'b0;
      #(2*Q);
   endtask

   // Release on the ninth clock and read the answer
   task automatic byte_out(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--)
         bit_out(d[i]);
      bit_in(b);
      ack = ~b;
   endtask

   // Last byte of a read is answered high
   task automatic byte_in(output logic [7:0] d, input logic give_ack);
      for (int i = 7; i >= 0; i--)
         bit_in(d[i]);
      bit_out(~give_ack);
   endtask
endmodule

// >>> testbench/tb_i2c_nonvolatile_byte_memory_slave.sv
// Self-checking bench for the byte-memory slave with a behavioural master.
// Assumes a pulled-up data wire; straps change only between frames.
`timescale 1ns/1ps
module tb_i2c_nonvolatile_byte_memory_slave;
   localparam logic [3:0] TYPE = 4'h6; // Arbitrary type code
   localparam logic [2:0] SEL = 3'h5;
   localparam time DLY = 2;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic wp = 1'b0;
   logic [2:0] pins = SEL;
   logic scl;
   logic mst_low;
   logic sda_o;
   logic sda_oe;
   logic busy;
   logic wr_pulse;
   logic blk_pulse;
   int bad_count = 0;
   int n_checks = 0;
   int wr_cnt = 0;
   int blk_cnt = 0;
   logic [7:0] pat [4] = '{8'h3c, 8'hc3, 8'h81, 8'h7e};
   // Pull-up: an unknown drive is not taken as pulling low
   wire sda = !(mst_low || (sda_oe === 1'b1 && sda_o === 1'b0));

   always #25 ref_clk = ~ref_clk;

   nvm_i2c_slave #(.TYPE_CODE(TYPE)) i_dut (.REF_CLK_I(ref_clk), .RST_I(rst), .SCL_I(scl),
      .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .DEVICE_SELECT_PINS_I(pins),
      .WP_I(wp), .BUSY_O(busy), .BYTE_WRITTEN_O(wr_pulse), .WRITE_BLOCKED_O(blk_pulse));
   nvm_bus_master i_mst (.scl_o(scl), .sda_low_o(mst_low), .sda_i(sda));

   // Count status pulses
   always @(posedge ref_clk)
   begin
      if (wr_pulse === 1'b1)
         wr_cnt++;
      if (blk_pulse === 1'b1)
         blk_cnt++;
   end

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic send(input logic [7:0] d, input logic exp_ack);
      logic a;
      i_mst.byte_out(d, a);
      check({7'h0, a}, {7'h0, exp_ack});
   endtask

   task automatic recv(input logic [7:0] exp, input logic more);
      logic [7:0] d;
      i_mst.byte_in(d, more);
      check(d, exp);
   endtask

   // Write frame up to and including the two address bytes
   task automatic head(input logic [12:0] a, input logic [2:0] up);
      i_mst.start();
      send({TYPE, SEL, 1'b0}, 1'b1);
      send({up, a[12:8]}, 1'b1);
      send(a[7:0], 1'b1);
   endtask

   task automatic rd_cur(input logic [7:0] exp);
      i_mst.start();
      send({TYPE, SEL, 1'b1}, 1'b1);
      recv(exp, 1'b0);
      i_mst.stop();
   endtask

   task automatic rd_at(input logic [12:0] a, input logic [7:0] exp);
      head(a, 3'h0);
      rd_cur(exp);
   endtask

   // Pulses land a few system clocks after the ninth rise
   task automatic wait_counts(input int ew, input int eb);
      int i;
      for (i = 0; i < 40 && (wr_cnt != ew || blk_cnt != eb); i++)
         @(posedge ref_clk);
      check(8'(wr_cnt), 8'(ew));
      check(8'(blk_cnt), 8'(eb));
      if (i == 40)
         end_sim();
   endtask

   initial
   begin
      repeat (100000) @(posedge ref_clk);
      bad_count++;
      end_sim();
   end

   initial
   begin
      // Link reset needs clock edges while reset is held
      fork
         i_mst.pulses(5);
         repeat (8) @(posedge ref_clk);
      join
      #DLY rst = 1'b0;
      i_mst.pulses(3);
      check({7'h0, sda_oe}, 8'h00);
      check({7'h0, busy}, 8'h00);
      // Page write across the top, upper three bits of the high byte left clear
      head(13'h1ffe, 3'h0);
      check({7'h0, busy}, 8'h01);
      for (int k = 0; k < 4; k++)
         send(pat[k], 1'b1);
      i_mst.stop();
      wait_counts(4, 0);
      // Random then sequential read, wrapping, then current read
      head(13'h1ffe, 3'h0);
      i_mst.start();
      send({TYPE, SEL, 1'b1}, 1'b1);
      for (int k = 0; k < 3; k++)
         recv(pat[k], k < 2);
      i_mst.stop();
      rd_cur(pat[3]);
      // Protected write still acks and advances the counter
      @(posedge ref_clk);
      #DLY wp = 1'b1;
      head(13'h0000, 3'h0);
      send(8'h5a, 1'b1);
      i_mst.stop();
      wait_counts(4, 1);
      @(posedge ref_clk);
      #DLY wp = 1'b0;
      rd_cur(pat[3]);
      rd_at(13'h0000, pat[2]);
      // Stop in mid byte discards the data
      head(13'h0001, 3'h0);
      for (int k = 0; k < 5; k++)
         i_mst.bit_out(1'b0);
      i_mst.stop();
      wait_counts(4, 1);
      rd_at(13'h0001, pat[3]);
      // Each select bit wrong, then a wrong type code
      for (int k = 0; k < 3; k++)
      begin
         i_mst.start();
         send({TYPE, SEL ^ (3'h1 << k), 1'b0}, 1'b0);
         i_mst.stop();
      end
      i_mst.start();
      send({TYPE ^ 4'h8, SEL, 1'b1}, 1'b0);
      i_mst.stop();
      // Straps at the open level
      @(posedge ref_clk);
      #DLY pins = 3'h0;
      i_mst.start();
      send({TYPE, 3'h0, 1'b0}, 1'b1);
      i_mst.stop();
      end_sim();
   end
endmodule
